// ===== logic/i2c_transfer_status.sv
// Purpose: read-only transfer status of the two-wire controller
// Assumes: engine events are one-cycle pulses on mclk_i
// Notes:   registers reached over a plain strobe port
//
// Local design decisions: the address map and the address-and-strobe port.
`include "xfer_status_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module i2c_transfer_status (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  // register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // engine events
  input  wire logic        xfer_start_i,
  input  wire logic [1:0]  xfer_kind_i,
  input  wire logic [1:0]  frame_type_i,
  input  wire logic        xfer_end_i,
  input  wire logic        byte_done_i,
  input  wire logic        byte_busy_i,
  input  wire logic        address_not_acked_i,
  input  wire logic        data_not_acked_i,
  input  wire logic        arbitration_lost_i,
  input  wire logic        start_cond_i,
  input  wire logic        stop_cond_i,
  input  wire logic        bus_error_i,
  input  wire logic        addr_match_i,
  input  wire logic        second_address_hit_i,
  // configuration
  input  wire logic        auto_general_call_mode_i,
  input  wire logic        controller_active_i,
  // outputs to engine and system
  output logic             rx_nack_o,
  output logic             irq_o
);

  typedef struct packed {
    xfer_status_pkg::phase_t phase;
    xfer_status_pkg::kind_t  kind;
    xfer_status_pkg::cause_t cause;
    xfer_status_pkg::frame_t frame;
    logic                    zero_len;
    logic                    dual;
    logic                    nack_req;
    logic                    done_p;
    logic                    abort_p;
    logic [31:0]             rdata;
  } core_state_t;

  core_state_t st_r;
  core_state_t st_nxt;

  xfer_evt_if evt ();

  logic [1:0]  irq_stat;
  logic [1:0]  irq_mask;
  logic        irq_w;
  logic [1:0]  state_code;
  logic [2:0]  cause_view;
  logic [31:0] ts_word;
  logic        busy;
  logic        is_master;
  logic        abort_now;
  xfer_status_pkg::cause_t abort_cause;

  // ==========================================================================
  // submodules
  xfer_len_counter u_len (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .evt     (evt)
  );

  xfer_irq_ctrl u_irq (
    .mclk_i    (mclk_i),
    .rst_b_i   (rst_b_i),
    .evt       (evt),
    .stat_wr_i (wr_i && addr_i == `IRQ_STAT_OFFSET),
    .mask_wr_i (wr_i && addr_i == `IRQ_MASK_OFFSET),
    .wdata_i   (wdata_i[1:0]),
    .stat_o    (irq_stat),
    .mask_o    (irq_mask),
    .irq_o     (irq_w)
  );

  // events toward counter and interrupt logic
  // a start refused while busy or disabled must not wipe the running count
  assign evt.clear_p  = xfer_start_i && !busy && controller_active_i;
  assign evt.byte_p   = byte_done_i && busy;
  assign evt.zero_len = st_r.zero_len;
  assign evt.kind     = st_r.kind;
  assign evt.done_p   = st_r.done_p;
  assign evt.abort_p  = st_r.abort_p;

  // ==========================================================================
  // field views
  assign busy      = st_r.phase == xfer_status_pkg::PH_BUSY;
  assign is_master = !st_r.kind[1];

  // phase to state code
  always_comb begin
    unique case (st_r.phase)
      xfer_status_pkg::PH_IDLE:  state_code = `ST_CODE_IDLE;
      xfer_status_pkg::PH_BUSY:  state_code = `ST_CODE_BUSY;
      xfer_status_pkg::PH_DONE:  state_code = `ST_CODE_DONE;
      xfer_status_pkg::PH_ABORT: state_code = `ST_CODE_ABORT;
    endcase
  end

  // stale cause hidden so software never misreads it
  assign cause_view = (st_r.phase == xfer_status_pkg::PH_ABORT) ? st_r.cause : 3'h0;

  // reserved ranges are constant zero
  assign ts_word = {2'h0, st_r.dual, 9'h000, evt.len, st_r.frame, cause_view,
                    state_code, st_r.kind};

  // ==========================================================================
  // abort detection, master causes for master kinds, slave causes for slave kinds
  always_comb begin
    abort_now   = 1'b0;
    abort_cause = xfer_status_pkg::CAUSE_ADDRESS_NOT_ACKED;
    if (is_master) begin
      if (address_not_acked_i) begin
        abort_now   = 1'b1;
        abort_cause = xfer_status_pkg::CAUSE_ADDRESS_NOT_ACKED;
      end else if (data_not_acked_i && st_r.kind == xfer_status_pkg::KIND_MASTER_WRITE) begin
        abort_now   = 1'b1;
        abort_cause = xfer_status_pkg::CAUSE_DATA_NOT_ACKED;
      end else if (arbitration_lost_i) begin
        abort_now   = 1'b1;
        abort_cause = xfer_status_pkg::CAUSE_ARBITRATION_LOST;
      end
    end else begin
      if (start_cond_i && byte_busy_i) begin
        abort_now   = 1'b1;
        abort_cause = xfer_status_pkg::CAUSE_EARLY_START_ERROR;
      end else if (stop_cond_i && byte_busy_i) begin
        abort_now   = 1'b1;
        abort_cause = xfer_status_pkg::CAUSE_EARLY_STOP_ERROR;
      end else if (evt.length_overflow_p) begin
        abort_now   = 1'b1;
        abort_cause = xfer_status_pkg::CAUSE_LENGTH_OVERFLOW;
      end
    end
  end

  // ==========================================================================
  // next state of the status core
  always_comb begin
    st_nxt         = st_r;
    st_nxt.done_p  = 1'b0;
    st_nxt.abort_p = 1'b0;
    st_nxt.rdata   = 32'h0000_0000;

    // phase machine
    unique case (st_r.phase)
      xfer_status_pkg::PH_IDLE,
      xfer_status_pkg::PH_DONE,
      xfer_status_pkg::PH_ABORT: begin
        if (xfer_start_i) begin
          st_nxt.phase    = xfer_status_pkg::PH_BUSY;
          st_nxt.kind     = xfer_status_pkg::kind_t'(xfer_kind_i);
          st_nxt.cause    = xfer_status_pkg::CAUSE_ADDRESS_NOT_ACKED;
          st_nxt.nack_req = 1'b0;
          st_nxt.frame    = (xfer_kind_i == xfer_status_pkg::KIND_SLAVE_RECEIVE) ?
                            xfer_status_pkg::frame_t'(frame_type_i) :
                            xfer_status_pkg::FRAME_NORMAL;
          st_nxt.zero_len = auto_general_call_mode_i &&
                            xfer_kind_i == xfer_status_pkg::KIND_SLAVE_RECEIVE &&
                            frame_type_i == xfer_status_pkg::FRAME_GENERAL_CALL;
        end
      end
      xfer_status_pkg::PH_BUSY: begin
        if (abort_now) begin
          st_nxt.phase   = xfer_status_pkg::PH_ABORT;
          st_nxt.cause   = abort_cause;
          st_nxt.done_p  = 1'b1;
          st_nxt.abort_p = 1'b1;
          if (abort_cause == xfer_status_pkg::CAUSE_LENGTH_OVERFLOW) begin
            st_nxt.nack_req = 1'b1;
          end
        end else if (xfer_end_i) begin
          st_nxt.phase  = xfer_status_pkg::PH_DONE;
          st_nxt.done_p = 1'b1;
        end
      end
    endcase

    // a disabled controller holds no transfer
    if (!controller_active_i) begin
      st_nxt.phase    = xfer_status_pkg::PH_IDLE;
      st_nxt.nack_req = 1'b0;
    end

    // nack request ends with the frame
    if (stop_cond_i || start_cond_i) begin
      st_nxt.nack_req = 1'b0;
    end

    // address flag: match wins over a start, stop or bus-error clear in the same cycle; a disabled controller clears it
    if (stop_cond_i || start_cond_i || bus_error_i || !controller_active_i) begin
      st_nxt.dual = 1'b0;
    end
    if (addr_match_i && controller_active_i) begin
      st_nxt.dual = second_address_hit_i;
    end

    // register read, data stand one cycle after the strobe
    if (rd_i) begin
      unique case (addr_i)
        `TS_OFFSET:       st_nxt.rdata = ts_word;
        `IRQ_STAT_OFFSET: st_nxt.rdata = {30'h0000_0000, irq_stat};
        `IRQ_MASK_OFFSET: st_nxt.rdata = {30'h0000_0000, irq_mask};
        default:          st_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // state register; writes to the status word have no path here
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r       <= '0;
      st_r.rdata <= `TS_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o   = st_r.rdata;
  assign rx_nack_o = st_r.nack_req;
  assign irq_o     = irq_w;

  // ==========================================================================
  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  AST_KIND_LATCH: assert property (
    xfer_start_i && !busy && controller_active_i |=> st_r.kind == $past(xfer_kind_i))
    else $error("transfer kind not captured at start");

  AST_BUSY_CODE: assert property (
    xfer_start_i && !busy && controller_active_i ##1 rd_i && addr_i == `TS_OFFSET
    |=> rdata_o[3:2] == `ST_CODE_BUSY)
    else $error("state code not in progress after start");

  AST_CAUSE_HIDDEN: assert property (
    rd_i && addr_i == `TS_OFFSET && st_r.phase != xfer_status_pkg::PH_ABORT
    |=> rdata_o[6:4] == 3'h0)
    else $error("cause visible outside abort");

  AST_ADDR_NACK: assert property (
    busy && is_master && address_not_acked_i && controller_active_i
    |=> st_r.phase == xfer_status_pkg::PH_ABORT &&
        st_r.cause == xfer_status_pkg::CAUSE_ADDRESS_NOT_ACKED)
    else $error("address nack not recorded");

  AST_DATA_NACK: assert property (
    busy && st_r.kind == xfer_status_pkg::KIND_MASTER_WRITE && !address_not_acked_i &&
    data_not_acked_i && controller_active_i
    |=> st_r.cause == xfer_status_pkg::CAUSE_DATA_NOT_ACKED)
    else $error("data nack not recorded");

  AST_ARBITRATION_LOST: assert property (
    busy && is_master && !address_not_acked_i && !data_not_acked_i &&
    arbitration_lost_i && controller_active_i
    |=> st_r.cause == xfer_status_pkg::CAUSE_ARBITRATION_LOST)
    else $error("arbitration loss not recorded");

  AST_EARLY_START: assert property (
    busy && !is_master && start_cond_i && byte_busy_i && controller_active_i
    |=> st_r.phase == xfer_status_pkg::PH_ABORT &&
        st_r.cause == xfer_status_pkg::CAUSE_EARLY_START_ERROR)
    else $error("early start not recorded");

  AST_EARLY_STOP: assert property (
    busy && !is_master && !start_cond_i && stop_cond_i && byte_busy_i && controller_active_i
    |=> st_r.cause == xfer_status_pkg::CAUSE_EARLY_STOP_ERROR)
    else $error("early stop not recorded");

  AST_LENGTH_OVERFLOW_NACK: assert property (
    busy && !is_master && !start_cond_i && !stop_cond_i && evt.length_overflow_p && controller_active_i
    |=> rx_nack_o && st_r.cause == xfer_status_pkg::CAUSE_LENGTH_OVERFLOW)
    else $error("overflow did not request nack");

  AST_DUAL_SET: assert property (
    addr_match_i && controller_active_i |=> st_r.dual == $past(second_address_hit_i))
    else $error("address flag wrong after match");

  AST_DUAL_CLR: assert property (
    (stop_cond_i || bus_error_i || !controller_active_i) && !addr_match_i |=> !st_r.dual)
    else $error("address flag not cleared");

  AST_DONE_PULSE: assert property (
    busy && xfer_end_i && !abort_now && controller_active_i
    |=> st_r.done_p && st_r.phase == xfer_status_pkg::PH_DONE ##1 !st_r.done_p)
    else $error("completion not flagged for one cycle");

  AST_RESERVED_ZERO: assert property (
    rd_i && addr_i == `TS_OFFSET |=> rdata_o[31:30] == 2'h0 && rdata_o[28:20] == 9'h000)
    else $error("reserved status bits not zero");

  AST_WRITE_IGNORED: assert property (
    wr_i && addr_i == `TS_OFFSET && !xfer_start_i && !busy && controller_active_i &&
    !addr_match_i && !stop_cond_i && !start_cond_i && !bus_error_i
    |=> $stable(st_r.kind) && $stable(st_r.phase) && $stable(st_r.dual))
    else $error("write changed the status word");

  CV_MASTER_DONE: cover property (
    busy && is_master ##1 st_r.phase == xfer_status_pkg::PH_DONE);
  CV_SLAVE_ABORT: cover property (
    busy && !is_master ##1 st_r.phase == xfer_status_pkg::PH_ABORT);
  CV_OVERFLOW: cover property (evt.length_overflow_p && busy);
  CV_IRQ: cover property (irq_o);

endmodule

`default_nettype wire

// ===== logic/xfer_evt_if.sv
// Purpose: events from the status core to the length counter and interrupt logic
// Assumes: all signals on mclk_i
// Notes:   pulses are one cycle wide
`timescale 1ns/10ps
`default_nettype none

interface xfer_evt_if;
  logic                  clear_p;
  logic                  byte_p;
  logic                  zero_len;
  xfer_status_pkg::kind_t kind;
  logic [10:0]           len;
  logic                  length_overflow_p;
  logic                  done_p;
  logic                  abort_p;

  modport core (output clear_p, output byte_p, output zero_len, output kind,
                output done_p, output abort_p, input len, input length_overflow_p);
  modport cnt  (input clear_p, input byte_p, input zero_len, input kind,
                output len, output length_overflow_p);
  modport irq  (input done_p, input abort_p);
endinterface

`default_nettype wire

// ===== logic/xfer_irq_ctrl.sv
// Purpose: sticky event bits, mask and level interrupt
// Assumes: write one to clear, same layout for mask
// Notes:   a new event wins over a clear in the same cycle
`include "xfer_status_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module xfer_irq_ctrl (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_b_i,
  // event carrier
  xfer_evt_if.irq         evt,
  // register access
  input  wire logic       stat_wr_i,
  input  wire logic       mask_wr_i,
  input  wire logic [1:0] wdata_i,
  output logic      [1:0] stat_o,
  output logic      [1:0] mask_o,
  output logic            irq_o
);

  typedef struct packed {
    logic [1:0] stat;
    logic [1:0] mask;
    logic       irq;
  } irq_state_t;

  irq_state_t st_r;
  irq_state_t st_nxt;
  logic [1:0] ev;

  // ==========================================================================
  // set wins over clear so no event is lost
  always_comb begin
    ev                  = 2'h0;
    ev[`IRQ_DONE_BIT]   = evt.done_p;
    ev[`IRQ_ABORT_BIT]  = evt.abort_p;
    st_nxt              = st_r;
    st_nxt.stat         = (st_r.stat & ~(stat_wr_i ? wdata_i : 2'h0)) | ev;
    if (mask_wr_i) begin
      st_nxt.mask = wdata_i;
    end
    st_nxt.irq = |(st_nxt.stat & st_nxt.mask);
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign stat_o = st_r.stat;
  assign mask_o = st_r.mask;
  assign irq_o  = st_r.irq;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  AST_DONE_IRQ: assert property (
    evt.done_p |=> st_r.stat[`IRQ_DONE_BIT])
    else $error("done event not recorded");

endmodule

`default_nettype wire

// ===== logic/xfer_len_counter.sv
// Purpose: byte count of the current transfer
// Assumes: byte pulses only while a transfer runs
// Notes:   overflow pulse one cycle after the refused byte
`include "xfer_status_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module xfer_len_counter (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_b_i,
  // event carrier
  xfer_evt_if.cnt   evt
);

  typedef struct packed {
    logic [10:0] len;
    logic        length_overflow;
  } cnt_state_t;

  cnt_state_t st_r;
  cnt_state_t st_nxt;

  // ==========================================================================
  // count bytes moved, with the per-kind limit handling
  always_comb begin
    st_nxt      = st_r;
    st_nxt.length_overflow = 1'b0;
    if (evt.clear_p) begin
      st_nxt.len = `LEN_ZERO;
    end else if (evt.byte_p && !evt.zero_len) begin
      if (st_r.len != `LEN_MAX) begin
        st_nxt.len = st_r.len + 11'h001;
      end else if (evt.kind == xfer_status_pkg::KIND_SLAVE_TRANSMIT) begin
        st_nxt.len = `LEN_ZERO;
      end else if (evt.kind == xfer_status_pkg::KIND_SLAVE_RECEIVE) begin
        st_nxt.length_overflow = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign evt.len    = st_r.len;
  assign evt.length_overflow_p = st_r.length_overflow;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  AST_TX_WRAP: assert property (
    evt.byte_p && !evt.clear_p && !evt.zero_len && st_r.len == `LEN_MAX &&
    evt.kind == xfer_status_pkg::KIND_SLAVE_TRANSMIT |=> st_r.len == `LEN_ZERO)
    else $error("slave transmit length did not wrap to zero");
  AST_GC_ZERO: assert property (
    evt.zero_len && !evt.clear_p |=> $stable(st_r.len))
    else $error("length moved during auto general call");

endmodule

`default_nettype wire

// ===== logic/xfer_status_defs.svh
// Purpose: offsets, field positions, reset values and codes of the transfer status block
// Assumes: byte addresses on an 8-bit register port, 32-bit data
// Notes:   definitions only
`ifndef XFER_STATUS_DEFS_SVH
`define XFER_STATUS_DEFS_SVH

// ==========================================================================
// register map
`define TS_OFFSET        8'h14
`define IRQ_STAT_OFFSET  8'h30
`define IRQ_MASK_OFFSET  8'h34
`define TS_RESET         32'h0000_0000

// ==========================================================================
// field layout of transfer_status
`define TS_KIND_LSB      0
`define TS_STATE_LSB     2
`define TS_CAUSE_LSB     4
`define TS_FRAME_LSB     7
`define TS_LEN_LSB       9
`define TS_DUAL_BIT      29

// ==========================================================================
// controller state codes and length limit
`define ST_CODE_IDLE     2'h0
`define ST_CODE_BUSY     2'h1
`define ST_CODE_DONE     2'h2
`define ST_CODE_ABORT    2'h3
`define LEN_MAX          11'h7FF
`define LEN_ZERO         11'h000

// ==========================================================================
// interrupt status bits
`define IRQ_DONE_BIT     0
`define IRQ_ABORT_BIT    1

`endif

// ===== logic/xfer_status_pkg.sv
// Purpose: shared types of the transfer status block
// Assumes: nothing beyond the defs header
// Notes:   field encodings are fixed by the register layout
package xfer_status_pkg;

  // ==========================================================================
  // field encodings
  typedef enum logic [1:0] {
    KIND_MASTER_WRITE   = 2'h0,
    KIND_MASTER_READ    = 2'h1,
    KIND_SLAVE_RECEIVE  = 2'h2,
    KIND_SLAVE_TRANSMIT = 2'h3
  } kind_t;

  typedef enum logic [2:0] {
    CAUSE_ADDRESS_NOT_ACKED = 3'h0,
    CAUSE_DATA_NOT_ACKED    = 3'h1,
    CAUSE_ARBITRATION_LOST  = 3'h3,
    CAUSE_EARLY_START_ERROR = 3'h4,
    CAUSE_EARLY_STOP_ERROR  = 3'h5,
    CAUSE_LENGTH_OVERFLOW   = 3'h6
  } cause_t;

  typedef enum logic [1:0] {
    FRAME_NORMAL                = 2'h0,
    FRAME_GENERAL_CALL          = 2'h1,
    FRAME_HARDWARE_GENERAL_CALL = 2'h2
  } frame_t;

  // ==========================================================================
  // controller phase machine
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_BUSY,
    PH_DONE,
    PH_ABORT
  } phase_t;

endpackage

// ===== tb/bus_peer_model.sv
// Purpose: stand-in for the two-wire engine and the peers on the bus
// Assumes: events change just after a rising edge of mclk_i
// Notes:   one byte every two cycles; no real wire timing is modelled
`timescale 1ns/10ps
`default_nettype none

module bus_peer_model (
  // clock
  input  wire logic        mclk_i,
  // engine events, bit order fixed in the bench
  output logic      [11:0] ev_o,
  output logic      [1:0]  kind_o,
  output logic      [1:0]  frame_o
);
  // ==========================================================================
  // quiet bus at time zero
  initial begin
    ev_o = 12'h000;
    kind_o = 2'h0;
    frame_o = 2'h0;
  end

  // one-cycle pulse on bit ev, with a level bit set beside it
  task automatic pulse(input int ev, input int lv, input logic val);
    @(posedge mclk_i);
    ev_o[ev] <= 1'b1;
    ev_o[lv] <= val;
    @(posedge mclk_i);
    ev_o[ev] <= 1'b0;
  endtask

  // whole transfer: start, n bytes, then one closing event (busy if asked)
  task automatic xfer(input logic [1:0] k, input logic [1:0] f, input int n, input int ev, input logic bsy);
    @(posedge mclk_i);
    kind_o <= k;
    frame_o <= f;
    pulse(0, 3, 1'b0);
    repeat (n) pulse(2, 3, 1'b0);
    pulse(ev, 3, bsy);
    ev_o[3] <= 1'b0;
  endtask
endmodule

`default_nettype wire

// ===== tb/tb_i2c_transfer_status.sv
// Purpose: self-checking bench of the transfer status block
// Assumes: peer model drives the engine events
// Notes:   register reads are checked a read after the event settles
`timescale 1ns/10ps
`default_nettype none

module tb_i2c_transfer_status;
  logic        mclk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        active = 1'b1;
  logic        agc = 1'b0;
  logic [31:0] rdata;
  logic        rx_nack;
  logic        irq;
  logic [11:0] ev;
  logic [1:0]  kind;
  logic [1:0]  frame;
  logic [31:0] st;
  int          fail_count = 0;
  int          checks = 0;

  // ==========================================================================
  // clock, design and peer
  always #4 mclk_i = ~mclk_i;

  i2c_transfer_status dut_u (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .xfer_start_i(ev[0]), .xfer_kind_i(kind), .frame_type_i(frame),
    .xfer_end_i(ev[1]), .byte_done_i(ev[2]), .byte_busy_i(ev[3]), .address_not_acked_i(ev[4]),
    .data_not_acked_i(ev[5]), .arbitration_lost_i(ev[6]), .start_cond_i(ev[7]), .stop_cond_i(ev[8]),
    .bus_error_i(ev[9]), .addr_match_i(ev[10]), .second_address_hit_i(ev[11]),
    .auto_general_call_mode_i(agc), .controller_active_i(active), .rx_nack_o(rx_nack), .irq_o(irq));

  bus_peer_model peer (.mclk_i(mclk_i), .ev_o(ev), .kind_o(kind), .frame_o(frame));

  // ==========================================================================
  // bus cycles and compare
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  function automatic logic [31:0] sw(logic [1:0] k, logic [1:0] s, logic [2:0] c, logic [1:0] f, logic [10:0] n);
    return {12'h000, n, f, c, s, k};
  endfunction

  // ==========================================================================
  // scenarios
  task automatic t_regs;
    rd_reg(8'h14, st);
    chk(st, 32'h0);
    wr_reg(8'h14, 32'hFFFF_FFFF);
    rd_reg(8'h14, st);
    chk(st, 32'h0);
    rd_reg(8'h40, st);
    chk(st, 32'h0);
  endtask

  // every kind completes; first one also walks mask and clear
  task automatic t_kinds;
    for (int k = 0; k < 4; k++) begin
      peer.xfer(k[1:0], 2'h0, 3, 1, 1'b0);
      rd_reg(8'h14, st);
      chk(st, sw(k[1:0], 2'h2, 3'h0, 2'h0, 11'h003));
      if (k == 0) begin
        chk(irq, 1'b0);
        rd_reg(8'h30, st);
        chk(st, 32'h1);
        wr_reg(8'h34, 32'h1);
        #1 chk(irq, 1'b1);
        wr_reg(8'h30, 32'h3);
        #1 chk(irq, 1'b0);
      end
    end
  endtask

  // abort table: kind, event bit, expected cause; every closing event is sent with busy set
  task automatic t_aborts;
    logic [1:0] kt[5] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3};
    int         et[5] = '{4, 5, 6, 7, 8};
    logic [2:0] ct[5] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5};
    for (int i = 0; i < 5; i++) begin
      peer.xfer(kt[i], 2'h0, 1, et[i], 1'b1);
      rd_reg(8'h14, st);
      chk(st[6:0], {ct[i], 2'h3, kt[i]});
    end
    rd_reg(8'h30, st);
    chk(st, 32'h3);
  endtask

  // receive past the limit aborts, transmit past it wraps the count
  task automatic t_long;
    fork
      peer.xfer(2'h2, 2'h0, 2048, 1, 1'b0);
      begin
        // read strobe lands one edge after the start is taken
        repeat (2) @(posedge mclk_i);
        rd_reg(8'h14, st);
        chk(st[3:0], 4'h6);
      end
    join
    rd_reg(8'h14, st);
    chk(st[6:0], 7'h6E);
    chk(rx_nack, 1'b1);
    peer.xfer(2'h3, 2'h0, 2048, 1, 1'b0);
    rd_reg(8'h14, st);
    chk(st, sw(2'h3, 2'h2, 3'h0, 2'h0, 11'h000));
  endtask

  task automatic t_frames;
    agc <= 1'b1;
    peer.xfer(2'h2, 2'h1, 2, 1, 1'b0);
    rd_reg(8'h14, st);
    chk(st, sw(2'h2, 2'h2, 3'h0, 2'h1, 11'h000));
    agc <= 1'b0;
    peer.xfer(2'h2, 2'h2, 1, 1, 1'b0);
    rd_reg(8'h14, st);
    chk(st, sw(2'h2, 2'h2, 3'h0, 2'h2, 11'h001));
  endtask

  // dual flag set by secondary match, cleared by each listed cause
  task automatic t_dual;
    int clr[3] = '{8, 7, 9};
    for (int i = 0; i < 4; i++) begin
      peer.pulse(10, 11, 1'b1);
      rd_reg(8'h14, st);
      chk(st[29], 1'b1);
      if (i < 3) peer.pulse(clr[i], 11, 1'b0);
      else active <= 1'b0;
      rd_reg(8'h14, st);
      chk(st[29], 1'b0);
      active <= 1'b1;
    end
    // secondary first, so a primary match has to pull the flag down
    peer.pulse(10, 11, 1'b1);
    peer.pulse(10, 11, 1'b0);
    rd_reg(8'h14, st);
    chk(st[29], 1'b0);
  endtask

  // ==========================================================================
  // verdict and main sequence
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    t_regs();
    t_kinds();
    t_aborts();
    t_long();
    t_frames();
    t_dual();
    summarize();
  end

  // hang guard
  initial begin
    repeat (90000) @(posedge mclk_i);
    fail_count++;
    summarize();
  end
endmodule

`default_nettype wire
